// [hdl/src_top.sv]
`timescale 1ns/1ns
`include "src_cfg.svh"

module src_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register port
    input src_pkg::src_bus_req_t busReq,
    output logic [31:0] rdata,
    // configuration from elsewhere
    input wire logic extendedIdEnable,
    // transaction lookup
    input src_pkg::src_txn_t txn,
    output src_pkg::src_route_t route,
    // external abort event
    input wire logic extAbort,
    input wire logic extAbortBankTied,
    // fault recording
    output src_pkg::src_fault_t faultRec,
    // secure control levels
    output logic [7:0] nsIrqCountOverride,
    output logic globalSpaceRestrict
);
    import src_pkg::*;

    logic [31:0] routeMem [`SRC_ROUTE_N];
    logic [31:0] scr1Reg;
    logic [31:0] rdataNext;
    logic cfgFaultSec;
    logic cfgFaultNs;
    logic [1:0] busIdx;
    logic busRoute;
    logic busScr1;
    logic accessOk;

    function automatic logic isSecGroup(input logic [1:0] idx);
        isSecGroup = (idx < 2'(`SRC_SEC_ROUTE_N));
    endfunction

    // stored bits depend on the format being written
    function automatic logic [31:0] routeMask(input logic [1:0] idx, input logic [31:0] d);
        logic [31:0] m;
        m = `SRC_BYP_MASK;
        if (d[`SRC_TYPE_HI] == 1'b1) begin
            m = `SRC_FAULT_MASK;
        end
        if (!`SRC_HAS_RA) begin
            m[`SRC_RA_HI:`SRC_RA_LO] = 2'b00;
        end
        if (!`SRC_HAS_SH) begin
            m[`SRC_SH_HI:`SRC_SH_LO] = 2'b00;
        end
        if (!`SRC_HAS_VMTAG) begin
            m[`SRC_TAG_HI:`SRC_TAG_LO] = 8'h00;
        end
        if (!isSecGroup(idx)) begin
            m[`SRC_NS_HI:`SRC_NS_LO] = 2'b00;
        end
        if (!`SRC_EXID_SUP) begin
            m[`SRC_EXV_BIT] = 1'b0;
        end
        routeMask = m;
    endfunction

    function automatic logic [31:0] scr1Mask();
        logic [31:0] m;
        m = 32'h0000_0000;
        m[`SRC_PERF_BIT] = 1'b1;
        m[`SRC_FETCH_BIT] = 1'b1;
        m[`SRC_EXTR_BIT] = 1'b1;
        m[`SRC_RESTR_BIT] = 1'b1;
        m[`SRC_REDIR_BIT] = `SRC_CFG_FAULTS;
        m[`SRC_IRQ_HI:`SRC_IRQ_LO] = `SRC_IRQ_MASK;
        if (!`SRC_TWO_SEC) begin
            m = 32'h0000_0000;
        end
        scr1Mask = m;
    endfunction

    assign busIdx = busReq.addr[3:2];
    assign busRoute = (busReq.addr >= `SRC_ROUTE_BASE) && (busReq.addr <= `SRC_ROUTE_LAST)
        && (busReq.addr[1:0] == 2'b00);
    assign busScr1 = (busReq.addr == `SRC_SCR1_ADDR) && `SRC_TWO_SEC;

    // access checks; non-secure blocks on secure registers or restricted space
    always_comb begin
        cfgFaultSec = 1'b0;
        cfgFaultNs = 1'b0;
        accessOk = busReq.secure;
        if (!busReq.secure && (busReq.wr || busReq.rd)) begin
            if (busScr1) begin
                cfgFaultSec = `SRC_CFG_FAULTS;
            end else if (busRoute && isSecGroup(busIdx)) begin
                cfgFaultSec = `SRC_CFG_FAULTS;
            end else if (busRoute && scr1Reg[`SRC_RESTR_BIT]) begin
                cfgFaultNs = `SRC_CFG_FAULTS;
            end else begin
                accessOk = 1'b1;
            end
        end
    end

    // route entries; reset value picked as fault format
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `SRC_ROUTE_N; i++) begin
                routeMem[i] <= `SRC_ROUTE_RST;
            end
        end else if (busReq.wr && busRoute && accessOk) begin
            routeMem[busIdx] <= busReq.wdata & routeMask(busIdx, busReq.wdata);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scr1Reg <= `SRC_SCR1_RST;
            scr1Reg[`SRC_IRQ_HI:`SRC_IRQ_LO] <= `SRC_NUM_IRQ & `SRC_IRQ_MASK;
        end else if (busReq.wr && busScr1 && accessOk) begin
            scr1Reg <= busReq.wdata & scr1Mask();
        end
    end

    always_comb begin
        rdataNext = 32'h0000_0000;
        if (busReq.rd && accessOk) begin
            if (busRoute) begin
                rdataNext = routeMem[busIdx];
            end else if (busScr1) begin
                rdataNext = scr1Reg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rdataNext;
        end
    end

    // no context irq count; only the override leaves
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            nsIrqCountOverride <= 8'h00;
            globalSpaceRestrict <= 1'b0;
        end else begin
            nsIrqCountOverride <= scr1Reg[`SRC_IRQ_HI:`SRC_IRQ_LO];
            globalSpaceRestrict <= scr1Reg[`SRC_RESTR_BIT];
        end
    end

    // transaction lookup, one cycle
    logic [31:0] ent;
    logic [1:0] entType;
    logic entSec;
    logic permHit;
    src_route_t routeNext;

    assign ent = routeMem[txn.entry];
    assign entType = ent[`SRC_TYPE_HI:`SRC_TYPE_LO];
    assign entSec = isSecGroup(txn.entry);

    always_comb begin
        routeNext = '0;
        routeNext.valid = txn.valid;
        case (entType)
            `SRC_TYPE_XLAT: routeNext.kind = SRC_CTX_XLAT;
            `SRC_TYPE_BYP: routeNext.kind = SRC_CTX_BYPASS;
            default: routeNext.kind = SRC_CTX_FAULT;
        endcase
        // secure bank choice trusted to software
        routeNext.bankIdx = (entType == `SRC_TYPE_XLAT) ? ent[`SRC_TAG_HI:`SRC_TAG_LO] : 8'h00;
        routeNext.invalidCtxFault = txn.valid && entType[1];
        permHit = txn.valid && scr1Reg[`SRC_FETCH_BIT] && txn.secure && txn.instrToNs;
        routeNext.permFault = permHit;
        if (entType == `SRC_TYPE_BYP) begin
            routeNext.readAllocHint = (ent[`SRC_RA_HI:`SRC_RA_LO] == `SRC_CODE_RSVD)
                ? `SRC_CODE_DEF : ent[`SRC_RA_HI:`SRC_RA_LO];
            // secure groups only, reserved code as default
            routeNext.securityAttrSelect = (entSec && ent[`SRC_NS_HI]) ? ent[`SRC_NS_HI:`SRC_NS_LO] : `SRC_CODE_DEF;
            routeNext.memoryTypeSelect = ent[`SRC_MT_BIT];
            routeNext.memoryAttributeValue = ent[`SRC_MT_BIT] ? ent[`SRC_MA_HI:`SRC_MA_LO] : 4'h0;
            routeNext.shareabilitySelect = ent[`SRC_SH_HI:`SRC_SH_LO];
            routeNext.virtualMachineTag = (entSec && !`SRC_SEC_VMTAG) ? 8'h00 : ent[`SRC_TAG_HI:`SRC_TAG_LO];
        end
        // validity only with extended ids on
        routeNext.extendedIdValid = extendedIdEnable && `SRC_EXID_SUP && ent[`SRC_EXV_BIT];
        routeNext.perfCount = txn.valid && txn.perfEvent && (!txn.secure || scr1Reg[`SRC_PERF_BIT]);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            route <= '0;
        end else begin
            route <= routeNext;
        end
    end

    // fault recording destinations
    src_fault_t faultNext;
    logic txnFault;
    always_comb begin
        faultNext = '0;
        txnFault = routeNext.invalidCtxFault || permHit;
        if (txnFault && txn.bankTied && entType == `SRC_TYPE_XLAT) begin
            faultNext.toBank = 1'b1;
        end else if (txnFault) begin
            faultNext.toSecureGlobal = 1'b1;
        end
        if (extAbort && extAbortBankTied) begin
            faultNext.toBank = 1'b1;
        end else if (extAbort && scr1Reg[`SRC_EXTR_BIT]) begin
            faultNext.toSecureGlobal = 1'b1;
        end else if (extAbort) begin
            faultNext.toGlobal = 1'b1;
        end
        if (cfgFaultSec && scr1Reg[`SRC_REDIR_BIT]) begin
            faultNext.toGlobal = 1'b1;
        end else if (cfgFaultSec) begin
            faultNext.toSecureGlobal = 1'b1;
        end
        if (cfgFaultNs) begin
            faultNext.toGlobal = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            faultRec <= '0;
        end else begin
            faultRec <= faultNext;
        end
    end

    // reserved type faults like fault type
    a_type_fault: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && entType == `SRC_TYPE_RSVD |=> route.kind == SRC_CTX_FAULT && route.invalidCtxFault)
        else $error("reserved type not treated as fault");

    a_memory_attribute_value_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
        !route.memoryTypeSelect |-> route.memoryAttributeValue == 4'h0)
        else $error("memory attribute leaked without select");

    a_exid_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
        !$past(extendedIdEnable) |-> !route.extendedIdValid)
        else $error("extended valid seen while disabled");

    a_scr1_secure: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq.wr && busScr1 && !busReq.secure |=> $stable(scr1Reg))
        else $error("non-secure write changed secure config");

    a_scr1_rdzero: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq.rd && busScr1 && !busReq.secure |=> rdata == 32'h0000_0000 && faultRec != '0)
        else $error("non-secure read of secure config not blocked");

    a_perf_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && txn.secure && txn.perfEvent && !scr1Reg[`SRC_PERF_BIT] |=> !route.perfCount)
        else $error("secure event counted while disabled");

    a_fetch_guard: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && txn.secure && txn.instrToNs && scr1Reg[`SRC_FETCH_BIT] |=> route.permFault)
        else $error("fetch guard fault missing");

    a_ext_redirect: assert property (@(posedge clk_sys) disable iff (!nrst)
        extAbort && !extAbortBankTied && scr1Reg[`SRC_EXTR_BIT] && !cfgFaultSec && !cfgFaultNs
        |=> faultRec.toSecureGlobal && !faultRec.toGlobal)
        else $error("external abort not redirected");

    a_restrict_block: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq.wr && busRoute && !busReq.secure && !isSecGroup(busIdx) && scr1Reg[`SRC_RESTR_BIT]
        |=> $stable(routeMem[2]) && $stable(routeMem[3]) && faultRec.toGlobal)
        else $error("restricted non-secure write not blocked");

    // redirect routes cfg fault to global
    a_cfg_redirect: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfgFaultSec && scr1Reg[`SRC_REDIR_BIT] |=> faultRec.toGlobal)
        else $error("cfg fault not redirected to global status");

    a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq.rd && !busRoute && !busScr1 |=> rdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    // fault format keeps only its fields
    a_fault_format: assert property (@(posedge clk_sys) disable iff (!nrst)
        ent[`SRC_TYPE_HI] |-> (ent & ~`SRC_FAULT_MASK) == 32'h0000_0000)
        else $error("fault format entry holds reserved bits");

    // security attribute absent in non-secure groups
    a_nsattr_rsvd: assert property (@(posedge clk_sys) disable iff (!nrst)
        !entSec |-> ent[`SRC_NS_HI:`SRC_NS_LO] == 2'b00)
        else $error("security attribute stored in non-secure group");

    a_bypass_kind: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && entType == `SRC_TYPE_BYP |=> route.valid && route.kind == SRC_CTX_BYPASS && !route.invalidCtxFault)
        else $error("bypass entry not decoded as bypass");

    // translation type hands out bank index
    a_xlat_bank: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && entType == `SRC_TYPE_XLAT
        |=> route.kind == SRC_CTX_XLAT && route.bankIdx == $past(ent[`SRC_TAG_HI:`SRC_TAG_LO]))
        else $error("translation entry bank index wrong");

    // reserved hint falls back to default
    a_rahint_rsvd: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && entType == `SRC_TYPE_BYP && ent[`SRC_RA_HI:`SRC_RA_LO] == `SRC_CODE_RSVD
        |=> route.readAllocHint == `SRC_CODE_DEF)
        else $error("reserved read hint passed through");

    a_share_pass: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && entType == `SRC_TYPE_BYP |=> route.shareabilitySelect == $past(ent[`SRC_SH_HI:`SRC_SH_LO]))
        else $error("shareability code lost");

    a_sec_tag: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && entSec && !`SRC_SEC_VMTAG |=> route.virtualMachineTag == 8'h00)
        else $error("secure vm tag leaked");

    a_irq_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
        (scr1Reg[`SRC_IRQ_HI:`SRC_IRQ_LO] & ~`SRC_IRQ_MASK) == 8'h00)
        else $error("unimplemented irq override bits set");

    // redirect bit has no say on these faults
    a_cfg_nsfault: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfgFaultNs |=> faultRec.toGlobal)
        else $error("non-secure register fault not in global status");

    // without redirect the fault stays secure
    a_cfg_secfault: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfgFaultSec && !scr1Reg[`SRC_REDIR_BIT] |=> faultRec.toSecureGlobal)
        else $error("cfg fault not in secure global status");

    // bank-tied abort goes to its bank
    a_abort_bank: assert property (@(posedge clk_sys) disable iff (!nrst)
        extAbort && extAbortBankTied |=> faultRec.toBank)
        else $error("bank-tied abort not recorded in bank");

    // bank-tied lookup fault on a translation entry goes to its bank
    a_txn_bank: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && txn.bankTied && entType == `SRC_TYPE_XLAT && permHit |=> faultRec.toBank)
        else $error("bank-tied fault not recorded in bank");

    a_perf_pass: assert property (@(posedge clk_sys) disable iff (!nrst)
        txn.valid && txn.perfEvent && (!txn.secure || scr1Reg[`SRC_PERF_BIT]) |=> route.perfCount)
        else $error("permitted event not counted");

endmodule

// [inc/src_cfg.svh]
`ifndef SRC_CFG_SVH
`define SRC_CFG_SVH

`define SRC_ADDR_W 8
`define SRC_ROUTE_N 4
`define SRC_SEC_ROUTE_N 2
`define SRC_ROUTE_BASE 8'h00
`define SRC_ROUTE_LAST 8'h0c
`define SRC_SCR1_ADDR 8'h40

`define SRC_HAS_RA 1'b1
`define SRC_HAS_SH 1'b1
`define SRC_HAS_VMTAG 1'b1
`define SRC_SEC_VMTAG 1'b0
`define SRC_EXID_SUP 1'b1
`define SRC_CFG_FAULTS 1'b1
`define SRC_TWO_SEC 1'b1
`define SRC_NUM_IRQ 8'h10
`define SRC_IRQ_MASK 8'h1f

`define SRC_IMPDEF_HI 31
`define SRC_IMPDEF_LO 28
`define SRC_RA_HI 21
`define SRC_RA_LO 20
`define SRC_NS_HI 19
`define SRC_NS_LO 18
`define SRC_TYPE_HI 17
`define SRC_TYPE_LO 16
`define SRC_MA_HI 15
`define SRC_MA_LO 12
`define SRC_MT_BIT 11
`define SRC_EXV_BIT 10
`define SRC_SH_HI 9
`define SRC_SH_LO 8
`define SRC_TAG_HI 7
`define SRC_TAG_LO 0

`define SRC_REDIR_BIT 28
`define SRC_PERF_BIT 27
`define SRC_FETCH_BIT 26
`define SRC_EXTR_BIT 25
`define SRC_RESTR_BIT 24
`define SRC_IRQ_HI 23
`define SRC_IRQ_LO 16

`define SRC_TYPE_XLAT 2'b00
`define SRC_TYPE_BYP 2'b01
`define SRC_TYPE_FAULT 2'b10
`define SRC_TYPE_RSVD 2'b11
`define SRC_CODE_DEF 2'b00
`define SRC_CODE_RSVD 2'b01
`define SRC_RA_ALLOC 2'b10
`define SRC_RA_NOALLOC 2'b11
`define SRC_NS_SEC 2'b10
`define SRC_NS_NONSEC 2'b11

`define SRC_BYP_MASK 32'h003f_ffff
`define SRC_FAULT_MASK 32'hf003_0000
`define SRC_ROUTE_RST 32'h0002_0000
`define SRC_SCR1_RST 32'h0000_0000

`endif

// [inc/src_pkg.sv]
package src_pkg;

    typedef enum logic [1:0] {
        SRC_CTX_XLAT,
        SRC_CTX_BYPASS,
        SRC_CTX_FAULT
    } src_ctx_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
        logic secure;
    } src_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] entry;
        logic secure;
        logic instrToNs;
        logic bankTied;
        logic perfEvent;
    } src_txn_t;

    typedef struct packed {
        logic valid;
        src_ctx_t kind;
        logic [7:0] bankIdx;
        logic invalidCtxFault;
        logic permFault;
        logic [1:0] readAllocHint;
        logic [1:0] securityAttrSelect;
        logic memoryTypeSelect;
        logic [3:0] memoryAttributeValue;
        logic extendedIdValid;
        logic [1:0] shareabilitySelect;
        logic [7:0] virtualMachineTag;
        logic perfCount;
    } src_route_t;

    typedef struct packed {
        logic toBank;
        logic toSecureGlobal;
        logic toGlobal;
    } src_fault_t;

endpackage

// [sim/tb_top.sv]
`timescale 1ns/1ns
`include "src_cfg.svh"

module tb_top;
    import src_pkg::*;
    logic clk_sys;
    logic nrst;
    src_bus_req_t busReq;
    logic [31:0] rdata;
    logic extendedIdEnable;
    src_txn_t txn;
    src_route_t route;
    logic extAbort;
    logic extAbortBankTied;
    src_fault_t faultRec;
    logic [7:0] nsIrqCountOverride;
    logic globalSpaceRestrict;
    int miscompares;
    int checked;
    logic [31:0] seed;
    logic [31:0] r;
    logic [31:0] d;
    logic [1:0] e;

    src_top DUT (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .busReq(busReq),
        .rdata(rdata),
        .extendedIdEnable(extendedIdEnable),
        .txn(txn),
        .route(route),
        .extAbort(extAbort),
        .extAbortBankTied(extAbortBankTied),
        .faultRec(faultRec),
        .nsIrqCountOverride(nsIrqCountOverride),
        .globalSpaceRestrict(globalSpaceRestrict)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] nextRand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // reserved code 01 comes out as default
    function automatic logic [1:0] fix(input logic [1:0] c);
        return (c == `SRC_CODE_RSVD) ? `SRC_CODE_DEF : c;
    endfunction

    function automatic logic [31:0] expEntry(input logic [1:0] n, input logic [31:0] v);
        logic [31:0] x;
        x = v[17] ? (v & `SRC_FAULT_MASK) : (v & `SRC_BYP_MASK);
        if (n[1])
            x[19:18] = 2'b00;
        return x;
    endfunction

    task automatic stop_test();
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one strobe cycle; result and fault pulse are read in the cycle after
    task automatic busOp(input logic [7:0] a, input logic [31:0] v, input logic w, input logic s);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: v, wr: w, rd: ~w, secure: s};
        @(posedge clk_sys);
        busReq.wr <= 1'b0;
        busReq.rd <= 1'b0;
        #1;
    endtask

    task automatic look(input logic [1:0] n, input logic s, input logic ins, input logic tied, input logic pe);
        @(posedge clk_sys);
        txn <= '{valid: 1'b1, entry: n, secure: s, instrToNs: ins, bankTied: tied, perfEvent: pe};
        @(posedge clk_sys);
        txn.valid <= 1'b0;
        #1;
    endtask

    task automatic abort(input logic tied);
        @(posedge clk_sys);
        extAbort <= 1'b1;
        extAbortBankTied <= tied;
        @(posedge clk_sys);
        extAbort <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        stop_test();
    end

    initial begin
        nrst = 1'b0;
        busReq = '0;
        txn = '0;
        extAbort = 1'b0;
        extAbortBankTied = 1'b0;
        extendedIdEnable = 1'b0;
        seed = 32'hb7bd1236;
        miscompares = 0;
        checked = 0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("irqCount", nsIrqCountOverride, `SRC_NUM_IRQ);
        chk("restrict", globalSpaceRestrict, 1'b0);
        busOp(`SRC_SCR1_ADDR, 32'h0, 1'b0, 1'b1);
        chk("scrReset", rdata, {8'h00, `SRC_NUM_IRQ, 16'h0000});
        for (int i = 0; i < 4; i++) begin
            busOp(8'(i * 4), 32'h0, 1'b0, 1'b1);
            chk("routeReset", rdata, `SRC_ROUTE_RST);
            look(2'(i), 1'b0, 1'b0, 1'b0, 1'b0);
            chk("ctxFault", route.invalidCtxFault, 1'b1);
            chk("faultDest", faultRec, 3'b010);
        end
        // first four pass every code of the hint and shareability fields, security codes 00 and 01 only into secure entries, the rest are random
        for (int i = 0; i < 28; i++) begin
            r = nextRand();
            e = (i < 4) ? 2'(i) : r[1:0];
            d = (i < 4) ? {10'h0, 2'(i), 2'(i), 2'b01, 4'ha, 2'b11, 2'(i), 8'h5a} : ((r & ~32'h3_0000) | 32'h1_0000);
            extendedIdEnable <= r[7];
            busOp({4'h0, e, 2'b00}, d, 1'b1, 1'b1);
            busOp({4'h0, e, 2'b00}, 32'h0, 1'b0, 1'b1);
            chk("routeRd", rdata, expEntry(e, d));
            look(e, 1'b0, 1'b0, 1'b0, 1'b0);
            chk("kind", {route.valid, route.kind}, {1'b1, SRC_CTX_BYPASS});
            chk("readAlloc", route.readAllocHint, fix(d[21:20]));
            chk("secAttr", route.securityAttrSelect, e[1] ? 2'b00 : fix(d[19:18]));
            chk("memType", route.memoryTypeSelect, d[11]);
            chk("memory_attribute_value", route.memoryAttributeValue, d[11] ? d[15:12] : 4'h0);
            chk("extValid", route.extendedIdValid, extendedIdEnable ? d[10] : 1'b0);
            chk("share", route.shareabilitySelect, d[9:8]);
            chk("vmTag", route.virtualMachineTag, e[1] ? d[7:0] : 8'h00);
            chk("noFault", {route.invalidCtxFault, faultRec}, 4'h0);
        end
        // both fault codes, bank-tied flag must not steer them to a bank
        for (int i = 0; i < 2; i++) begin
            d = i ? 32'hffff_ffff : 32'hfffe_ffff;
            busOp(8'h08, d, 1'b1, 1'b1);
            busOp(8'h08, 32'h0, 1'b0, 1'b1);
            chk("faultRd", rdata, d & `SRC_FAULT_MASK);
            look(2'd2, 1'b0, 1'b0, 1'b1, 1'b0);
            chk("faultKind", route.kind, SRC_CTX_FAULT);
            chk("faultDest", {route.invalidCtxFault, faultRec}, 4'b1010);
        end
        // bank index read through a non-secure entry
        busOp(8'h0c, 32'h0000_0037, 1'b1, 1'b1);
        look(2'd3, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("bankIdx", {route.kind, route.bankIdx}, {SRC_CTX_XLAT, 8'h37});
        // no bank setup, so flipping restrict is safe
        busOp(`SRC_SCR1_ADDR, 32'hffff_ffff, 1'b1, 1'b1);
        busOp(`SRC_SCR1_ADDR, 32'h0, 1'b0, 1'b1);
        chk("scrRd", rdata, 32'h1f1f_0000);
        chk("levels", {globalSpaceRestrict, nsIrqCountOverride}, 9'h11f);
        busOp(8'h08, 32'h0, 1'b0, 1'b0);
        chk("restrictRd", {rdata, faultRec}, {32'h0, 3'b001});
        busOp(8'h08, 32'h0000_0037, 1'b1, 1'b0);
        chk("restrictWr", faultRec, 3'b001);
        busOp(8'h08, 32'h0, 1'b0, 1'b1);
        chk("restrictKeep", rdata, 32'hf003_0000);
        busOp(`SRC_SCR1_ADDR, 32'h0, 1'b0, 1'b0);
        chk("redirRd", {rdata, faultRec}, {32'h0, 3'b001});
        look(2'd3, 1'b1, 1'b1, 1'b1, 1'b1);
        chk("guardOn", {route.perfCount, route.permFault, faultRec}, 5'b11100);
        abort(1'b0);
        chk("extRedir", faultRec, 3'b010);
        abort(1'b1);
        chk("extBank", faultRec, 3'b100);
        busOp(`SRC_SCR1_ADDR, 32'h0, 1'b1, 1'b1);
        look(2'd3, 1'b1, 1'b1, 1'b1, 1'b1);
        chk("guardOff", {route.perfCount, route.permFault, faultRec}, 5'b00000);
        abort(1'b0);
        chk("extPlain", faultRec, 3'b001);
        busOp(`SRC_SCR1_ADDR, 32'hffff_ffff, 1'b1, 1'b0);
        chk("nsWrFault", faultRec, 3'b010);
        busOp(`SRC_SCR1_ADDR, 32'h0, 1'b0, 1'b1);
        chk("nsWrIgnored", rdata, 32'h0);
        busOp(8'h0c, 32'h0, 1'b0, 1'b0);
        chk("nsCommon", {rdata, faultRec}, {32'h0000_0037, 3'b000});
        busOp(8'h04, 32'h0, 1'b0, 1'b0);
        chk("nsSecEntry", {rdata, faultRec}, {32'h0, 3'b010});
        busOp(8'h20, 32'h0, 1'b0, 1'b1);
        chk("unmapped", {rdata, faultRec}, {32'h0, 3'b000});
        stop_test();
    end
endmodule
